// file: dv/flash_link_chk.sv
/*
 checker of the command link between controller and flash device.
 assumes one clock, presetn asynchronous active low, signals taken from the interface.
*/
`timescale 1ns/1ns
module flash_link_chk
    import flash_cmd_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link
    input wire logic valid,
    input wire logic write,
    input wire logic wide,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic done,
    input wire logic ready_oe,
    input wire logic ready_level
);
    // cycles since valid rose; saturates so a hung request cannot wrap into a match
    logic [4:0] cyc_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_r <= 5'h00;
        end else if (!valid) begin
            cyc_r <= 5'h00;
        end else if (cyc_r != 5'h1f) begin
            cyc_r <= cyc_r + 5'h01;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_narrow_write_len: assert property (done && write && !wide |-> cyc_r == LEN_WRITE_NARROW)
        else $error("narrow write answered at wrong cycle");
    a_narrow_read_len: assert property (done && !write && !wide |-> cyc_r == LEN_READ_NARROW)
        else $error("narrow read answered at wrong cycle");
    a_wide_len: assert property (done && wide |-> cyc_r == LEN_WIDE)
        else $error("wide cycle answered at wrong cycle");
    a_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_done_needs_req: assert property (done |-> valid)
        else $error("done without request");
    a_request_held: assert property (valid && !done |=> valid && $stable(addr) && $stable(wdata))
        else $error("request changed before answer");
    a_valid_drop: assert property (done |=> !valid)
        else $error("request kept after answer");
    a_busy_status: assert property (done && !write && ready_oe && $past(ready_oe, 2)
        |-> !rdata[ST_READY])
        else $error("status shows ready while busy");
    c_wide: cover property (done && wide);
    c_narrow_read: cover property (done && !write && !wide);
    c_busy_end: cover property ($fell(ready_oe) && ready_level);
endmodule // flash_link_chk

// file: dv/tb.sv
/*
 bench: controller and flash device joined by the link, orders given over apb.
 assumes pclk at 50 mhz; erase of sector 9 takes 8192 clocks, so the ceiling is 60000.
*/
`timescale 1ns/1ns
module tb;
    import flash_cmd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [PADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_SECTORS-1:0] lock_bits = '0;
    logic top_boot_protect_n = 1'b1;
    logic general_protect_n = 1'b1;
    // id codes handed to the device; the values are arbitrary
    localparam logic [7:0] MFR_CODE = 8'h6b;
    localparam logic [7:0] DEV_CODE = 8'hc4;
    logic [31:0] rd;
    logic err;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    flash_link_if link();
    flash_host_ctrl i_flash_host_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link.host));
    flash_command_decoder #(.PROG_CYCLES(2), .MFR_ID(MFR_CODE), .DEV_ID(DEV_CODE))
        i_flash_command_decoder (.pclk(pclk), .presetn(presetn), .lock_bits(lock_bits),
        .top_boot_protect_n(top_boot_protect_n), .general_protect_n(general_protect_n),
        .link(link.device));
    flash_link_chk i_flash_link_chk (.pclk(pclk), .presetn(presetn), .valid(link.valid),
        .write(link.write), .wide(link.wide), .addr(link.addr), .wdata(link.wdata),
        .rdata(link.rdata), .done(link.done), .ready_oe(link.ready_oe),
        .ready_level(link.ready_level));
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one command cycle on the link, then poll until the controller is free
    task automatic op(input logic w, input logic wd, input logic [ADDR_W-1:0] a,
        input logic [7:0] d);
        apb(1'b1, REG_ADDR, {13'h0000, a});
        apb(1'b1, REG_DATA, {24'h000000, d});
        apb(1'b1, REG_CMD, {30'h00000000, wd, w});
        do apb(1'b0, REG_STAT, 32'h00000000); while (rd[STAT_BUSY] !== 1'b0);
    endtask
    task automatic rd_chk(input string nm, input logic wd, input logic [ADDR_W-1:0] a,
        input logic [7:0] e);
        op(1'b0, wd, a, 8'h00);
        chk(nm, {24'h000000, rd[15:8]}, {24'h000000, e});
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        op(1'b1, 1'b1, SEC_S9_BASE, CMD_SECTOR_ERASE);
        op(1'b1, 1'b1, SEC_S9_BASE + 19'h00010, CMD_CONFIRM);
        op(1'b1, 1'b0, SEC_S9_BASE, CMD_READ_ARRAY);
        op(1'b0, 1'b0, SEC_S9_BASE, 8'h00);
        chk("busy bit", {31'h00000000, rd[15]}, 32'h00000000);
        do apb(1'b0, REG_STAT, 32'h00000000); while (rd[STAT_DEV_READY] !== 1'b1);
        rd_chk("erase status", 1'b1, SEC_S9_BASE, 8'h80);
        op(1'b1, 1'b0, 19'h00000, CMD_READ_ARRAY);
        rd_chk("erased top", 1'b1, SEC_S9_BASE + 19'h01fff, ERASED_BYTE);
        for (int i = 0; i < 2; i++) begin
            op(1'b1, i[0], SEC_S9_BASE + 19'(i), i ? CMD_PROGRAM_ALT : CMD_PROGRAM);
            op(1'b1, i[0], SEC_S9_BASE + 19'(i), 8'h3c + 8'(i));
            rd_chk("prog status", 1'b0, SEC_S9_BASE, 8'h80);
        end
        op(1'b1, 1'b0, 19'h00000, CMD_READ_ARRAY);
        rd_chk("prog byte 0", 1'b0, SEC_S9_BASE, 8'h3c);
        rd_chk("prog byte 1", 1'b1, SEC_S9_BASE + 19'h00001, 8'h3d);
        // second reset in mid-run from status mode; the array keeps its bytes
        op(1'b1, 1'b1, 19'h00000, CMD_READ_STATUS);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("after reset", 1'b0, SEC_S9_BASE + 19'h00001, 8'h3d);
        op(1'b1, 1'b1, 19'h00000, CMD_READ_ID);
        rd_chk("mfr id", 1'b1, ID_MFR_ADDR, MFR_CODE);
        op(1'b1, 1'b1, 19'h00000, 8'h33);
        rd_chk("dev id", 1'b0, ID_DEV_ADDR, DEV_CODE);
        lock_bits[9] <= 1'b1;
        op(1'b1, 1'b1, SEC_S9_BASE + 19'h00002, CMD_PROGRAM);
        op(1'b1, 1'b1, SEC_S9_BASE + 19'h00002, 8'h00);
        rd_chk("lock status", 1'b1, SEC_S9_BASE, 8'h92);
        op(1'b1, 1'b1, 19'h00000, CMD_CLEAR_STATUS);
        op(1'b1, 1'b1, 19'h00000, CMD_READ_STATUS);
        rd_chk("cleared", 1'b1, 19'h00000, 8'h80);
        lock_bits <= '0;
        op(1'b1, 1'b1, SEC_S9_BASE, CMD_SECTOR_ERASE);
        op(1'b1, 1'b1, SEC_S9_BASE, 8'h00);
        rd_chk("seq error", 1'b1, SEC_S9_BASE, 8'hb0);
        op(1'b1, 1'b1, 19'h00000, CMD_CLEAR_STATUS);
        general_protect_n <= 1'b0;
        op(1'b1, 1'b1, SEC_S9_BASE + 19'h00003, CMD_PROGRAM);
        op(1'b1, 1'b1, SEC_S9_BASE + 19'h00003, 8'h00);
        rd_chk("wp pin", 1'b1, SEC_S9_BASE, 8'h92);
        op(1'b1, 1'b1, 19'h00000, CMD_CLEAR_STATUS);
        general_protect_n <= 1'b1;
        top_boot_protect_n <= 1'b0;
        op(1'b1, 1'b1, SUB_REGION_BASE, CMD_UNIFORM_ERASE);
        op(1'b1, 1'b1, SUB_REGION_BASE, CMD_CONFIRM);
        rd_chk("boot pin", 1'b1, SUB_REGION_BASE, 8'ha2);
        // a first cycle of a program while the error is still held is refused
        op(1'b1, 1'b1, SEC_S9_BASE, CMD_PROGRAM);
        chk("refused", {30'h00000000, rd[STAT_REFUSED:STAT_ERR_HOLD]}, 32'h00000003);
        op(1'b1, 1'b1, 19'h00000, CMD_READ_ARRAY);
        rd_chk("kept byte", 1'b1, SEC_S9_BASE, 8'h3c);
        rd_chk("unlocked kept", 1'b1, SEC_S9_BASE + 19'h00002, ERASED_BYTE);
        apb(1'b0, 12'h010, 32'h00000000);
        chk("unmapped", {31'h00000000, err}, 32'h00000001);
        print_verdict();
    end
endmodule // tb

// file: rtl/flash_cmd_pkg.sv
/*
 shared constants of the flash command link: command codes, bus cycle lengths,
 status bit positions, sector map, id addresses and controller register offsets.
 assumes a 19-bit byte address (4 Mbit array) and 8-bit data.
*/
package flash_cmd_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int NUM_SECTORS = 11;

    // command codes and the erased byte value
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h21;
    localparam logic [7:0] CMD_UNIFORM_ERASE = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // bus transaction lengths in clock cycles
    localparam logic [4:0] LEN_WRITE_NARROW = 5'h11;
    localparam logic [4:0] LEN_READ_NARROW = 5'h13;
    localparam logic [4:0] LEN_WIDE = 5'h01;

    // status flag bit positions
    localparam int ST_READY = 7;
    localparam int ST_ERASE_FAIL = 5;
    localparam int ST_PROG_FAIL = 4;
    localparam int ST_PROTECT = 1;

    // sector map
    localparam logic [3:0] SEC_BOOT = 4'ha;
    localparam logic [3:0] SEC_S9 = 4'h9;
    localparam logic [3:0] SEC_S8 = 4'h8;
    localparam logic [3:0] SEC_FIRST_SUB = 4'h7;
    localparam logic [2:0] SUB_REGION_TOP = 3'h7;
    localparam logic [ADDR_W-1:0] SEC_BOOT_BASE = 19'h78000;
    localparam logic [ADDR_W-1:0] SEC_S9_BASE = 19'h76000;
    localparam logic [ADDR_W-1:0] SEC_S8_BASE = 19'h74000;
    localparam logic [ADDR_W-1:0] SUB_REGION_BASE = 19'h70000;
    localparam logic [ADDR_W-1:0] ADDR_TOP = 19'h7ffff;
    localparam logic [ADDR_W-1:0] MAIN_OFS_MASK = 19'h0ffff;

    // product id addresses
    localparam logic [ADDR_W-1:0] ID_MFR_ADDR = 19'h00000;
    localparam logic [ADDR_W-1:0] ID_DEV_ADDR = 19'h00001;

    // controller register offsets and fields
    localparam int PADDR_W = 12;
    localparam logic [PADDR_W-1:0] REG_ADDR = 12'h000;
    localparam logic [PADDR_W-1:0] REG_DATA = 12'h004;
    localparam logic [PADDR_W-1:0] REG_CMD = 12'h008;
    localparam logic [PADDR_W-1:0] REG_STAT = 12'h00c;
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_WIDE_BIT = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DEV_READY = 1;
    localparam int STAT_ERR_HOLD = 2;
    localparam int STAT_REFUSED = 3;
    localparam int STAT_RDATA_LSB = 8;

    typedef enum {MODE_ARRAY, MODE_STATUS, MODE_ID} read_mode_t;
    typedef enum {PEND_NONE, PEND_ERASE, PEND_UNIFORM, PEND_PROGRAM} pend_t;
    typedef enum {WSM_IDLE, WSM_ERASE, WSM_PROGRAM} wsm_t;
    typedef enum {HOST_IDLE, HOST_BUSY} host_state_t;
endpackage

// file: rtl/flash_command_decoder.sv
/*
 flash device end: bus cycle timing, command_user_interface, write_state_machine,
 status_flags and the byte array. assumes lock bits come from logic on pclk and the
 two protect pins come straight from the board.
*/
`timescale 1ns/1ns
module flash_command_decoder
    import flash_cmd_pkg::*;
#(
    parameter int PROG_CYCLES = 10,
    parameter logic [7:0] MFR_ID = 8'h5a, // arbitrary value
    parameter logic [7:0] DEV_ID = 8'ha5  // arbitrary value
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // protection
    input wire logic [NUM_SECTORS-1:0] lock_bits,
    input wire logic top_boot_protect_n,
    input wire logic general_protect_n,
    // link
    flash_link_if.device link
);
    // a zero count would wrap to a 65536-cycle program; the timer is 16 bits
    if (PROG_CYCLES < 1 || PROG_CYCLES > 65535) begin : g_prog_check
        $error("PROG_CYCLES out of range");
    end

    localparam logic [15:0] PROG_LAST = 16'(PROG_CYCLES - 1);

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    logic tbl_meta_r, tbl_r, wp_meta_r, wp_r;
    logic [4:0] cnt_r;
    logic [4:0] len;
    logic take;
    logic done_r;
    logic [DATA_W-1:0] rdata_r;
    read_mode_t mode_r;
    pend_t pend_r;
    wsm_t wsm_r;
    logic erase_fail_r, prog_fail_r, protect_r;
    logic [ADDR_W-1:0] ptr_r, last_r, prog_addr_r;
    logic [DATA_W-1:0] prog_data_r;
    logic [15:0] timer_r;
    logic [3:0] sec;
    logic [ADDR_W-1:0] lo, hi;
    logic prot;
    logic [DATA_W-1:0] status;
    logic prog_end;

    // pins from the board are resynchronised before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbl_meta_r <= 1'b1;
            tbl_r <= 1'b1;
            wp_meta_r <= 1'b1;
            wp_r <= 1'b1;
        end else begin
            tbl_meta_r <= top_boot_protect_n;
            tbl_r <= tbl_meta_r;
            wp_meta_r <= general_protect_n;
            wp_r <= wp_meta_r;
        end
    end

    // command cycle length: the wide port completes in one clock
    always_comb begin
        if (link.wide) begin
            len = LEN_WIDE;
        end else if (link.write) begin
            len = LEN_WRITE_NARROW;
        end else begin
            len = LEN_READ_NARROW;
        end
    end

    assign take = link.valid && !done_r && (cnt_r == len - 5'h01);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end else begin
            done_r <= take;
            if (!link.valid || done_r || take) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 5'h01;
            end
        end
    end

    // target sector, erase bounds and protection for the address on the link
    always_comb begin
        if (link.addr[ADDR_W-1 -: 3] != SUB_REGION_TOP) begin
            sec = {1'b0, link.addr[ADDR_W-1 -: 3]};
        end else if (link.addr >= SEC_BOOT_BASE) begin
            sec = SEC_BOOT;
        end else if (link.addr >= SEC_S9_BASE) begin
            sec = SEC_S9;
        end else if (link.addr >= SEC_S8_BASE) begin
            sec = SEC_S8;
        end else begin
            sec = SEC_FIRST_SUB;
        end
        case (sec)
            SEC_BOOT: begin
                lo = SEC_BOOT_BASE;
                hi = ADDR_TOP;
            end
            SEC_S9: begin
                lo = SEC_S9_BASE;
                hi = SEC_BOOT_BASE - 19'h00001;
            end
            SEC_S8: begin
                lo = SEC_S8_BASE;
                hi = SEC_S9_BASE - 19'h00001;
            end
            SEC_FIRST_SUB: begin
                lo = SUB_REGION_BASE;
                hi = SEC_S8_BASE - 19'h00001;
            end
            default: begin
                lo = link.addr & ~MAIN_OFS_MASK;
                hi = link.addr | MAIN_OFS_MASK;
            end
        endcase
        prot = lock_bits[sec] || ((sec == SEC_BOOT) ? !tbl_r : !wp_r);
        if (pend_r == PEND_UNIFORM && sec >= SEC_FIRST_SUB) begin
            lo = SUB_REGION_BASE;
            hi = ADDR_TOP;
            prot = (|lock_bits[NUM_SECTORS-1:SEC_FIRST_SUB]) || !tbl_r;
        end
    end

    assign prog_end = (wsm_r == WSM_PROGRAM) && (timer_r == PROG_LAST);

    // command user interface and write state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= MODE_ARRAY;
            pend_r <= PEND_NONE;
            wsm_r <= WSM_IDLE;
            erase_fail_r <= 1'b0;
            prog_fail_r <= 1'b0;
            protect_r <= 1'b0;
            ptr_r <= '0;
            last_r <= '0;
            prog_addr_r <= '0;
            prog_data_r <= '0;
            timer_r <= '0;
        end else begin
            case (wsm_r)
                WSM_ERASE: begin
                    ptr_r <= ptr_r + 19'h00001;
                    if (ptr_r == last_r) begin
                        wsm_r <= WSM_IDLE;
                    end
                end
                WSM_PROGRAM: begin
                    timer_r <= timer_r + 16'h0001;
                    if (prog_end) begin
                        wsm_r <= WSM_IDLE;
                    end
                end
                default: ;
            endcase
            if (take && link.write) begin
                if (pend_r != PEND_NONE) begin
                    pend_r <= PEND_NONE;
                    mode_r <= MODE_STATUS;
                    if (pend_r == PEND_PROGRAM) begin
                        if (prot) begin
                            prog_fail_r <= 1'b1;
                            protect_r <= 1'b1;
                        end else begin
                            wsm_r <= WSM_PROGRAM;
                            prog_addr_r <= link.addr;
                            prog_data_r <= link.wdata;
                            timer_r <= '0;
                        end
                    end else if (link.wdata != CMD_CONFIRM) begin
                        erase_fail_r <= 1'b1;
                        prog_fail_r <= 1'b1;
                    end else if (prot) begin
                        erase_fail_r <= 1'b1;
                        protect_r <= 1'b1;
                    end else begin
                        wsm_r <= WSM_ERASE;
                        ptr_r <= lo;
                        last_r <= hi;
                    end
                end else begin
                    case (link.wdata)
                        CMD_READ_ARRAY: begin
                            if (wsm_r == WSM_IDLE) begin
                                mode_r <= MODE_ARRAY;
                            end
                        end
                        CMD_READ_STATUS: begin
                            mode_r <= MODE_STATUS;
                        end
                        CMD_CLEAR_STATUS: begin
                            erase_fail_r <= 1'b0;
                            prog_fail_r <= 1'b0;
                            protect_r <= 1'b0;
                        end
                        CMD_READ_ID: begin
                            if (wsm_r == WSM_IDLE) begin
                                mode_r <= MODE_ID;
                            end
                        end
                        CMD_SECTOR_ERASE: begin
                            if (wsm_r == WSM_IDLE) begin
                                pend_r <= PEND_ERASE;
                            end
                        end
                        CMD_UNIFORM_ERASE: begin
                            if (wsm_r == WSM_IDLE) begin
                                pend_r <= PEND_UNIFORM;
                            end
                        end
                        CMD_PROGRAM, CMD_PROGRAM_ALT: begin
                            if (wsm_r == WSM_IDLE) begin
                                pend_r <= PEND_PROGRAM;
                            end
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

    // array writes; programming only clears bits, so unerased bytes cannot recover ones
    always_ff @(posedge pclk) begin
        if (wsm_r == WSM_ERASE) begin
            mem[ptr_r] <= ERASED_BYTE;
        end else if (prog_end) begin
            mem[prog_addr_r] <= mem[prog_addr_r] & prog_data_r;
        end
    end

    always_comb begin
        status = '0;
        status[ST_READY] = (wsm_r == WSM_IDLE);
        status[ST_ERASE_FAIL] = erase_fail_r;
        status[ST_PROG_FAIL] = prog_fail_r;
        status[ST_PROTECT] = protect_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= '0;
        end else if (take && !link.write) begin
            case (mode_r)
                MODE_STATUS: rdata_r <= status;
                MODE_ID: begin
                    if (link.addr == ID_MFR_ADDR) begin
                        rdata_r <= MFR_ID;
                    end else if (link.addr == ID_DEV_ADDR) begin
                        rdata_r <= DEV_ID;
                    end else begin
                        rdata_r <= '0;
                    end
                end
                default: rdata_r <= mem[link.addr];
            endcase
        end
    end

    assign link.rdata = rdata_r;
    assign link.done = done_r;
    assign link.ready_oe = (wsm_r != WSM_IDLE);
endmodule // flash_command_decoder

// file: rtl/flash_host_ctrl.sv
/*
 controller end: apb registers that issue one flash command cycle per order.
 assumes the flash device shares pclk and answers every request with done.
*/
`timescale 1ns/1ns
module flash_host_ctrl
    import flash_cmd_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link
    flash_link_if.host link
);
    host_state_t state_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] data_r;
    logic [DATA_W-1:0] rdata_r;
    logic write_r, wide_r;
    logic err_hold_r, refused_r, status_view_r, second_r;
    logic wr_acc, go, first_mod, blocked, mapped, err_seen;

    assign mapped = (paddr == REG_ADDR) || (paddr == REG_DATA) || (paddr == REG_CMD)
                    || (paddr == REG_STAT);
    assign wr_acc = psel && penable && pwrite && mapped;
    assign go = wr_acc && (paddr == REG_CMD) && (state_r == HOST_IDLE);
    // first cycles that would start an erase or program
    assign first_mod = !second_r && ((data_r == CMD_SECTOR_ERASE)
                       || (data_r == CMD_UNIFORM_ERASE) || (data_r == CMD_PROGRAM)
                       || (data_r == CMD_PROGRAM_ALT));
    assign blocked = pwdata[CMD_WRITE_BIT] && err_hold_r && first_mod;
    assign err_seen = status_view_r && link.rdata[ST_READY]
                      && (link.rdata[ST_ERASE_FAIL] || link.rdata[ST_PROG_FAIL]
                      || link.rdata[ST_PROTECT]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_r <= '0;
            data_r <= '0;
        end else if (wr_acc && paddr == REG_ADDR) begin
            addr_r <= pwdata[ADDR_W-1:0];
        end else if (wr_acc && paddr == REG_DATA) begin
            data_r <= pwdata[DATA_W-1:0];
        end
    end

    // one request held until the device answers; narrow cycles take 17 or 19 clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= HOST_IDLE;
            write_r <= 1'b0;
            wide_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            case (state_r)
                HOST_IDLE: begin
                    if (go && !blocked) begin
                        state_r <= HOST_BUSY;
                        write_r <= pwdata[CMD_WRITE_BIT];
                        wide_r <= pwdata[CMD_WIDE_BIT];
                    end
                end
                HOST_BUSY: begin
                    if (link.done) begin
                        state_r <= HOST_IDLE;
                        if (!write_r) begin
                            rdata_r <= link.rdata;
                        end
                    end
                end
                default: state_r <= HOST_IDLE;
            endcase
        end
    end

    // tracks what the device returns so that a reported error forces a clear first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_hold_r <= 1'b0;
            status_view_r <= 1'b0;
            second_r <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            if (state_r == HOST_BUSY && link.done && write_r) begin
                second_r <= !second_r && first_mod;
                if (second_r || data_r == CMD_READ_STATUS) begin
                    status_view_r <= 1'b1;
                end else if (data_r == CMD_READ_ARRAY || data_r == CMD_READ_ID) begin
                    status_view_r <= 1'b0;
                end
                if (!second_r && data_r == CMD_CLEAR_STATUS) begin
                    err_hold_r <= 1'b0;
                end
            end else if (state_r == HOST_BUSY && link.done && err_seen) begin
                err_hold_r <= 1'b1;
            end
            // a refusal in the same cycle as the clear wins
            if (go && blocked) begin
                refused_r <= 1'b1;
            end else if (wr_acc && paddr == REG_STAT) begin
                refused_r <= 1'b0;
            end
        end
    end

    // software must erase a sector before programming; bits only go from one to zero
    assign link.valid = (state_r == HOST_BUSY);
    assign link.write = write_r;
    assign link.wide = wide_r;
    assign link.addr = addr_r;
    assign link.wdata = data_r;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        prdata = '0;
        case (paddr)
            REG_ADDR: prdata[ADDR_W-1:0] = addr_r;
            REG_DATA: prdata[DATA_W-1:0] = data_r;
            REG_STAT: begin
                prdata[STAT_BUSY] = (state_r == HOST_BUSY);
                prdata[STAT_DEV_READY] = link.ready_level;
                prdata[STAT_ERR_HOLD] = err_hold_r;
                prdata[STAT_REFUSED] = refused_r;
                prdata[STAT_RDATA_LSB +: DATA_W] = rdata_r;
            end
            default: prdata = '0;
        endcase
    end
endmodule // flash_host_ctrl

// file: rtl/flash_link_if.sv
/*
 command link between controller and flash device: one command cycle per request.
 assumes both ends run on the same clock; ready line is open drain with pull-up.
*/
`timescale 1ns/1ns
interface flash_link_if;
    import flash_cmd_pkg::*;
    logic valid;
    logic write;
    logic wide;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic ready_oe;
    logic ready_level;

    // pull-up wins unless the device sinks the line
    assign ready_level = !ready_oe;

    modport device (input valid, input write, input wide, input addr, input wdata,
                    output rdata, output done, output ready_oe);
    modport host (output valid, output write, output wide, output addr, output wdata,
                  input rdata, input done, input ready_level);
endinterface // flash_link_if
